/* File: rtl/spdb_cfg.svh */
// Register map, field positions, reset values and prescale counts.
`ifndef SPDB_CFG_SVH
`define SPDB_CFG_SVH

// ==========================================================================
// Register offsets on the plain register port
`define SPDB_ADDR_W          4
`define SPDB_OFS_RX_DATA     4'h0
`define SPDB_OFS_TX_DATA     4'h1
`define SPDB_OFS_DIV_LOW     4'h2
`define SPDB_OFS_DIV_HIGH    4'h3
`define SPDB_OFS_RX_STAT     4'h4
`define SPDB_OFS_TX_STAT     4'h5
`define SPDB_OFS_BAUD_CTRL   4'h6
`define SPDB_OFS_IRQ_STATUS  4'h7
`define SPDB_OFS_IRQ_MASK    4'h8

// ==========================================================================
// Field positions
`define SPDB_BIT_NINTH       0
`define SPDB_BIT_RX_AVAIL    1
`define SPDB_BIT_TX_EMPTY    1
`define SPDB_BIT_HIGH_SPEED  2
`define SPDB_BIT_WIDE        3
`define SPDB_BIT_SYNC        4
`define SPDB_BIT_NINE_EN     6
`define SPDB_IRQ_RX          0
`define SPDB_IRQ_TX          1
`define SPDB_IRQ_OVERRUN     2

// ==========================================================================
// Reset values and prescale terminal counts (factor minus one)
`define SPDB_RESET_BYTE      8'h00
`define SPDB_PRESCALE_SLOW   6'h3f
`define SPDB_PRESCALE_MID    6'h0f
`define SPDB_PRESCALE_FAST   6'h03

`endif

/* File: rtl/spdb_pkg.sv */
// Types shared by the serial port data and baud register front end.
package spdb_pkg;

  typedef logic [7:0] spdb_byte_t;
  typedef logic [8:0] spdb_char_t;
  typedef logic [2:0] spdb_irq_t;

  typedef struct packed {
    spdb_byte_t rdata;
    spdb_byte_t tx_data;
    spdb_byte_t div_lo;
    spdb_byte_t div_hi;
    spdb_char_t rx_head;
    spdb_char_t rx_next;
    spdb_char_t tx_char;
    logic       rx_head_v;
    logic       rx_next_v;
    logic       tx_full;
    logic       tx_ninth;
    logic       rx_nine_en;
    logic       tx_nine_en;
    logic       high_speed;
    logic       sync_mode;
    logic       wide;
    logic       restart;
    spdb_irq_t  irq_status;
    spdb_irq_t  irq_mask;
  } spdb_regs_t;

  typedef struct packed {
    logic [5:0]  prescale;
    logic [15:0] count;
    logic        tick;
  } spdb_baud_st_t;

endpackage

/* File: rtl/spdb_baud_if.sv */
// Connection between the register front end and the baud rate counter.
`timescale 1ns/1ns
`default_nettype none
interface spdb_baud_if;
  logic [15:0] divisor;
  logic        wide;
  logic        high_speed;
  logic        sync_mode;
  logic        restart;
  logic        tick;
  modport ctrl (output divisor, wide, high_speed, sync_mode, restart,
                input tick);
  modport gen  (input divisor, wide, high_speed, sync_mode, restart,
                output tick);
endinterface
`default_nettype wire

/* File: rtl/spdb_baud_gen.sv */
// Baud rate counter: prescaler and divisor count, one tick per period.
`timescale 1ns/1ns
`default_nettype none
`include "spdb_cfg.svh"
module spdb_baud_gen (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  spdb_baud_if.gen baud
);
  import spdb_pkg::*;

  spdb_baud_st_t s;
  spdb_baud_st_t next_s;
  logic [5:0]    pre_top;
  logic [15:0]   limit;

  // ========================================================================
  // Counter
  always_comb begin
    if (baud.sync_mode) begin
      pre_top = `SPDB_PRESCALE_FAST;
    end else if (baud.wide) begin
      pre_top = baud.high_speed ? `SPDB_PRESCALE_FAST
                                : `SPDB_PRESCALE_MID;
    end else begin
      pre_top = baud.high_speed ? `SPDB_PRESCALE_MID
                                : `SPDB_PRESCALE_SLOW;
    end
    limit = baud.wide ? baud.divisor
                      : {8'h00, baud.divisor[7:0]};
    next_s      = s;
    next_s.tick = 1'b0;
    // Compare with >= so a mode change never strands the count above
    // its new terminal value.
    if (baud.restart) begin
      next_s.prescale = 6'h00;
      next_s.count    = 16'h0000;
    end else if (s.prescale >= pre_top) begin
      next_s.prescale = 6'h00;
      if (s.count >= limit) begin
        next_s.count = 16'h0000;
        next_s.tick  = 1'b1;
      end else begin
        next_s.count = s.count + 16'h0001;
      end
    end else begin
      next_s.prescale = s.prescale + 6'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign baud.tick = s.tick;

  // ========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic [23:0] period;
  logic [23:0] period_q;
  logic [23:0] gap;
  logic        clean;
  logic [5:0]  pre_q;
  logic [15:0] limit_q;

  assign period = (24'(pre_top) + 24'h000001) * (24'(limit) + 24'h000001);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap      <= 24'h000000;
      clean    <= 1'b0;
      pre_q    <= 6'h00;
      limit_q  <= 16'h0000;
      period_q <= 24'h000000;
    end else begin
      pre_q    <= pre_top;
      limit_q  <= limit;
      period_q <= period;
      if (baud.restart) begin
        gap <= 24'hffffff;
      end else if (s.tick) begin
        gap <= 24'h000000;
      end else begin
        gap <= gap + 24'h000001;
      end
      if (baud.restart || s.tick) begin
        clean <= 1'b1;
      end else if (pre_top != pre_q || limit != limit_q) begin
        clean <= 1'b0;
      end
    end
  end

  baud_period_a: assert property (
    (s.tick && clean) |-> (gap == period_q - 24'h000001))
    else $error("Baud tick period does not match divisor and mode.");

  restart_quiet_a: assert property (
    baud.restart |=> !baud.tick [*3])
    else $error("Baud tick too soon after a counter restart.");

endmodule
`default_nettype wire

/* File: rtl/spdb_regs.sv */
// Serial port data and baud divisor register front end.
`timescale 1ns/1ns
`default_nettype none
`include "spdb_cfg.svh"

module spdb_regs (
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic [`SPDB_ADDR_W-1:0] reg_addr_i,
  input  wire spdb_pkg::spdb_byte_t    reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic                         irq_o,
  output spdb_pkg::spdb_byte_t         reg_rdata_o,
  input  wire logic                    rx_char_valid_i,
  input  wire spdb_pkg::spdb_char_t    rx_char_i,
  output logic                         tx_char_valid_o,
  output spdb_pkg::spdb_char_t         tx_char_o,
  input  wire logic                    tx_char_take_i,
  output logic                         baud_tick_o,
  output logic                         sync_mode_o,
  output logic                         rx_nine_en_o,
  output logic                         tx_nine_en_o
);
  import spdb_pkg::*;

  spdb_regs_t s;
  spdb_regs_t next_s;
  spdb_byte_t rx_stat;
  spdb_byte_t tx_stat;
  spdb_byte_t baud_ctrl;
  spdb_irq_t  irq_set;
  spdb_irq_t  irq_clr;
  logic       rx_pop;
  logic       tx_load;
  logic       tx_taken;

  spdb_baud_if baud_bus ();

  // ========================================================================
  // Status views
  always_comb begin
    rx_stat                      = 8'h00;
    rx_stat[`SPDB_BIT_NINTH]     = s.rx_head[8];
    rx_stat[`SPDB_BIT_RX_AVAIL]  = s.rx_head_v;
    rx_stat[`SPDB_BIT_NINE_EN]   = s.rx_nine_en;
    tx_stat                      = 8'h00;
    tx_stat[`SPDB_BIT_NINTH]     = s.tx_ninth;
    tx_stat[`SPDB_BIT_TX_EMPTY]  = !s.tx_full;
    tx_stat[`SPDB_BIT_HIGH_SPEED] = s.high_speed;
    tx_stat[`SPDB_BIT_SYNC]      = s.sync_mode;
    tx_stat[`SPDB_BIT_NINE_EN]   = s.tx_nine_en;
    baud_ctrl                    = 8'h00;
    baud_ctrl[`SPDB_BIT_WIDE]    = s.wide;
  end

  // ========================================================================
  // Next state
  always_comb begin
    next_s         = s;
    next_s.rdata   = `SPDB_RESET_BYTE;
    next_s.restart = 1'b0;
    irq_set        = 3'h0;
    irq_clr        = 3'h0;
    rx_pop   = reg_rd_i && (reg_addr_i == `SPDB_OFS_RX_DATA)
               && s.rx_head_v;
    tx_taken = tx_char_take_i && s.tx_full;
    // The holding slot frees in the same cycle the engine takes it, so a
    // write in that cycle is not refused.
    tx_load  = reg_wr_i && (reg_addr_i == `SPDB_OFS_TX_DATA)
               && (!s.tx_full || tx_taken);

    if (reg_rd_i) begin
      case (reg_addr_i)
        `SPDB_OFS_RX_DATA: begin
          next_s.rdata = s.rx_head[7:0];
        end
        `SPDB_OFS_TX_DATA: begin
          next_s.rdata = s.tx_data;
        end
        `SPDB_OFS_DIV_LOW: begin
          next_s.rdata = s.div_lo;
        end
        `SPDB_OFS_DIV_HIGH: begin
          next_s.rdata = s.div_hi;
        end
        `SPDB_OFS_RX_STAT: begin
          next_s.rdata = rx_stat;
        end
        `SPDB_OFS_TX_STAT: begin
          next_s.rdata = tx_stat;
        end
        `SPDB_OFS_BAUD_CTRL: begin
          next_s.rdata = baud_ctrl;
        end
        `SPDB_OFS_IRQ_STATUS: begin
          next_s.rdata = {5'h00, s.irq_status};
        end
        `SPDB_OFS_IRQ_MASK: begin
          next_s.rdata = {5'h00, s.irq_mask};
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end

    if (reg_wr_i) begin
      case (reg_addr_i)
        `SPDB_OFS_DIV_LOW: begin
          next_s.div_lo  = reg_wdata_i;
          next_s.restart = 1'b1;
        end
        `SPDB_OFS_DIV_HIGH: begin
          next_s.div_hi  = reg_wdata_i;
          next_s.restart = 1'b1;
        end
        `SPDB_OFS_RX_STAT: begin
          next_s.rx_nine_en = reg_wdata_i[`SPDB_BIT_NINE_EN];
        end
        `SPDB_OFS_TX_STAT: begin
          next_s.tx_ninth   = reg_wdata_i[`SPDB_BIT_NINTH];
          next_s.high_speed = reg_wdata_i[`SPDB_BIT_HIGH_SPEED];
          next_s.sync_mode  = reg_wdata_i[`SPDB_BIT_SYNC];
          next_s.tx_nine_en = reg_wdata_i[`SPDB_BIT_NINE_EN];
        end
        `SPDB_OFS_BAUD_CTRL: begin
          next_s.wide = reg_wdata_i[`SPDB_BIT_WIDE];
        end
        `SPDB_OFS_IRQ_STATUS: begin
          irq_clr = reg_wdata_i[2:0];
        end
        `SPDB_OFS_IRQ_MASK: begin
          next_s.irq_mask = reg_wdata_i[2:0];
        end
        default: begin
          irq_clr = 3'h0;
        end
      endcase
    end

    // Transmit holding slot. The ninth bit is sampled at the data write,
    // which is why software must set it first.
    if (tx_taken) begin
      next_s.tx_full         = 1'b0;
      irq_set[`SPDB_IRQ_TX]  = 1'b1;
    end
    if (tx_load) begin
      next_s.tx_data = reg_wdata_i;
      next_s.tx_char = {s.tx_ninth, reg_wdata_i};
      next_s.tx_full = 1'b1;
    end

    // Two-entry receive buffer: the visible head and one waiting behind.
    if (rx_pop) begin
      next_s.rx_head   = s.rx_next;
      next_s.rx_head_v = s.rx_next_v;
      next_s.rx_next_v = 1'b0;
    end
    if (rx_char_valid_i) begin
      irq_set[`SPDB_IRQ_RX] = 1'b1;
      if (!next_s.rx_head_v) begin
        next_s.rx_head   = rx_char_i;
        next_s.rx_head_v = 1'b1;
      end else if (!next_s.rx_next_v) begin
        next_s.rx_next   = rx_char_i;
        next_s.rx_next_v = 1'b1;
      end else begin
        // Both slots hold unread data; the newest character is dropped
        // so the oldest stays intact for software.
        irq_set[`SPDB_IRQ_OVERRUN] = 1'b1;
      end
    end

    // A new event in the same cycle as its clear keeps the bit set.
    next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================================
  // Baud counter
  assign baud_bus.divisor    = {s.div_hi, s.div_lo};
  assign baud_bus.wide       = s.wide;
  assign baud_bus.high_speed = s.high_speed;
  assign baud_bus.sync_mode  = s.sync_mode;
  assign baud_bus.restart    = s.restart;

  spdb_baud_gen u_baud_gen (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .baud      (baud_bus)
  );

  // ========================================================================
  // Outputs
  assign reg_rdata_o     = s.rdata;
  assign tx_char_valid_o = s.tx_full;
  assign tx_char_o       = s.tx_char;
  assign baud_tick_o     = baud_bus.tick;
  assign sync_mode_o     = s.sync_mode;
  assign rx_nine_en_o    = s.rx_nine_en;
  assign tx_nine_en_o    = s.tx_nine_en;
  assign irq_o           = |(s.irq_status & s.irq_mask);

  // ========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  rx_data_read_a: assert property (
    (reg_rd_i && reg_addr_i == `SPDB_OFS_RX_DATA)
    |=> (reg_rdata_o == $past(s.rx_head[7:0])))
    else $error("Receive data read returned the wrong byte.");

  rx_ninth_read_a: assert property (
    (reg_rd_i && reg_addr_i == `SPDB_OFS_RX_STAT)
    |=> (reg_rdata_o[`SPDB_BIT_NINTH] == $past(s.rx_head[8])))
    else $error("Receive ninth bit does not match the held character.");

  rx_head_hold_a: assert property (
    (rx_char_valid_i && s.rx_head_v && !rx_pop)
    |=> ($stable(s.rx_head) && s.rx_head_v))
    else $error("Arriving character disturbed the unread character.");

  // A read of another register may stand between the pop and the next read.
  rx_release_a: assert property (
    (rx_pop && s.rx_next_v)
    ##1 !(reg_rd_i && reg_addr_i == `SPDB_OFS_RX_DATA)
    ##1 (reg_rd_i && reg_addr_i == `SPDB_OFS_RX_DATA)
    |=> (reg_rdata_o == $past(s.rx_next[7:0], 3)))
    else $error("Second read did not show the next buffered character.");

  tx_load_a: assert property (
    (reg_wr_i && reg_addr_i == `SPDB_OFS_TX_DATA && !s.tx_full)
    |=> (tx_char_valid_o
         && tx_char_o == {$past(s.tx_ninth), $past(reg_wdata_i)}))
    else $error("Transmit character not loaded from data and ninth bit.");

  tx_refill_a: assert property (
    (tx_char_take_i && s.tx_full && reg_wr_i
     && reg_addr_i == `SPDB_OFS_TX_DATA)
    |=> (tx_char_valid_o && tx_char_o[7:0] == $past(reg_wdata_i)))
    else $error("Transmit write refused while previous began shifting.");

  tx_taken_a: assert property (
    (tx_char_take_i && s.tx_full && !tx_load) |=> !tx_char_valid_o)
    else $error("Transmit slot not freed after the engine took it.");

  div_low_restart_a: assert property (
    (reg_wr_i && reg_addr_i == `SPDB_OFS_DIV_LOW)
    |=> (baud_bus.restart && baud_bus.divisor[7:0] == $past(reg_wdata_i))
    ##1 (baud_bus.restart
         == $past(reg_wr_i && (reg_addr_i == `SPDB_OFS_DIV_LOW
                               || reg_addr_i == `SPDB_OFS_DIV_HIGH))))
    else $error("Low divisor write did not store and restart once.");

  div_high_restart_a: assert property (
    (reg_wr_i && reg_addr_i == `SPDB_OFS_DIV_HIGH)
    |=> (baud_bus.restart
         && baud_bus.divisor[15:8] == $past(reg_wdata_i)))
    else $error("High divisor write did not store and restart.");

  irq_level_a: assert property (
    (rx_char_valid_i && s.irq_mask[`SPDB_IRQ_RX]
     && !(reg_wr_i && reg_addr_i == `SPDB_OFS_IRQ_MASK)) |=> irq_o)
    else $error("Unmasked receive event did not raise the interrupt.");

  rdata_idle_a: assert property (
    !reg_rd_i |=> (reg_rdata_o == 8'h00))
    else $error("Read data not cleared outside the answer cycle.");

  rx_avail_a: assert property (
    rx_char_valid_i |=> (s.rx_head_v && s.irq_status[`SPDB_IRQ_RX]))
    else $error("Arriving character not held or not flagged.");

  rx_overrun_a: assert property (
    (rx_char_valid_i && s.rx_head_v && s.rx_next_v && !rx_pop)
    |=> (s.irq_status[`SPDB_IRQ_OVERRUN]
         && $stable(s.rx_next) && s.rx_next_v))
    else $error("Overrun did not keep the waiting character.");

  rx_empty_read_a: assert property (
    (reg_rd_i && reg_addr_i == `SPDB_OFS_RX_DATA && !s.rx_head_v
     && !rx_char_valid_i)
    |=> (!s.rx_head_v && $stable(s.rx_head)))
    else $error("Reading an empty receive register changed the buffer.");

  tx_refused_a: assert property (
    (reg_wr_i && reg_addr_i == `SPDB_OFS_TX_DATA && s.tx_full
     && !tx_char_take_i)
    |=> (tx_char_valid_o && $stable(tx_char_o)))
    else $error("Transmit write into a full slot was not refused.");

  tx_freed_irq_a: assert property (
    (tx_char_take_i && s.tx_full) |=> s.irq_status[`SPDB_IRQ_TX])
    else $error("Freed transmit slot did not set its event bit.");

  divisor_hold_a: assert property (
    !(reg_wr_i && (reg_addr_i == `SPDB_OFS_DIV_LOW
                   || reg_addr_i == `SPDB_OFS_DIV_HIGH))
    |=> $stable(baud_bus.divisor))
    else $error("Baud divisor changed without a divisor write.");

  wide_select_a: assert property (
    (reg_wr_i && reg_addr_i == `SPDB_OFS_BAUD_CTRL)
    |=> (baud_bus.wide == $past(reg_wdata_i[`SPDB_BIT_WIDE])))
    else $error("Wide divisor select not taken from the control write.");

  mode_bits_a: assert property (
    (reg_wr_i && reg_addr_i == `SPDB_OFS_TX_STAT)
    |=> (sync_mode_o == $past(reg_wdata_i[`SPDB_BIT_SYNC])
         && baud_bus.high_speed
            == $past(reg_wdata_i[`SPDB_BIT_HIGH_SPEED])))
    else $error("Baud mode bits not taken from the status write.");

  tx_ninth_a: assert property (
    (reg_wr_i && reg_addr_i == `SPDB_OFS_TX_STAT)
    |=> (s.tx_ninth == $past(reg_wdata_i[`SPDB_BIT_NINTH])
         && $stable(tx_char_o)))
    else $error("Ninth transmit bit write disturbed the held character.");

  irq_clear_a: assert property (
    (reg_wr_i && reg_addr_i == `SPDB_OFS_IRQ_STATUS && !rx_char_valid_i
     && !tx_char_take_i)
    |=> ((s.irq_status & $past(reg_wdata_i[2:0])) == 3'h0))
    else $error("Writing a one did not clear the event bit.");

endmodule
`default_nettype wire

/* File: testbench/spdb_far_end.sv */
// Model of the shift engines that sit beyond the register front end.
`timescale 1ns/1ns
`default_nettype none
module spdb_far_end (
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 tx_char_valid_i,
  input  wire spdb_pkg::spdb_char_t tx_char_i,
  output logic                      tx_char_take_o,
  output logic                      rx_char_valid_o,
  output spdb_pkg::spdb_char_t      rx_char_o
);
  import spdb_pkg::*;
  int         take_delay = 3;
  int         wait_cnt   = 0;
  spdb_char_t sent_q[$];

  initial begin
    tx_char_take_o  = 1'b0;
    rx_char_valid_o = 1'b0;
    rx_char_o       = 9'h000;
  end

  // ==========================================================================
  // Transmit engine: starts shifting a full slot after a set delay.
  always @(posedge sys_clk_i) begin
    tx_char_take_o <= 1'b0;
    if (reset_n_i && tx_char_valid_i && !tx_char_take_o) begin
      if (wait_cnt >= take_delay) begin
        tx_char_take_o <= 1'b1;
        sent_q.push_back(tx_char_i);
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end

  // ==========================================================================
  // Receive engine: one completed character per call.
  // The idle data show the inverse so that a stale sample cannot match.
  task automatic send(input spdb_char_t c);
    @(posedge sys_clk_i);
    rx_char_valid_o <= 1'b1;
    rx_char_o       <= c;
    @(posedge sys_clk_i);
    rx_char_valid_o <= 1'b0;
    rx_char_o       <= ~c;
  endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking testbench for the serial port data and baud front end.
`timescale 1ns/1ns
`default_nettype none
`include "spdb_cfg.svh"
module testbench;
  import spdb_pkg::*;
  logic                    sys_clk_i;
  logic                    reset_n_i;
  logic [`SPDB_ADDR_W-1:0] reg_addr_i;
  spdb_byte_t              reg_wdata_i;
  logic                    reg_wr_i;
  logic                    reg_rd_i;
  logic                    irq_o;
  spdb_byte_t              reg_rdata_o;
  logic                    rx_valid;
  spdb_char_t              rx_char;
  logic                    tx_valid;
  spdb_char_t              tx_char;
  logic                    tx_take;
  logic                    tick;
  logic                    sync_mode;
  logic                    rx_nine;
  logic                    tx_nine;
  int                      fail_count = 0;
  int                      n_checks   = 0;
  int                      cnt;

  spdb_regs dut_u (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .irq_o(irq_o), .reg_rdata_o(reg_rdata_o), .rx_char_valid_i(rx_valid),
    .rx_char_i(rx_char), .tx_char_valid_o(tx_valid), .tx_char_o(tx_char),
    .tx_char_take_i(tx_take), .baud_tick_o(tick),
    .sync_mode_o(sync_mode), .rx_nine_en_o(rx_nine), .tx_nine_en_o(tx_nine)
  );

  spdb_far_end far_u (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .tx_char_valid_i(tx_valid), .tx_char_i(tx_char),
    .tx_char_take_o(tx_take), .rx_char_valid_o(rx_valid),
    .rx_char_o(rx_char)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================================
  // Checking and bus tasks
  task automatic check(input string n, input logic [15:0] e,
                       input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input spdb_byte_t d);
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // Back-to-back transmit writes: only one beside the engine's take lands.
  task automatic wr_burst(input spdb_byte_t d, input int n);
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= `SPDB_OFS_TX_DATA;
    reg_wdata_i <= d;
    repeat (n) @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe is taken.
  task automatic rd(input logic [3:0] a, input spdb_byte_t e);
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    check($sformatf("register %0h", a), {8'h00, e}, {8'h00, reg_rdata_o});
  endtask

  task automatic next_tick;
    cnt = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      cnt++;
    end while (tick !== 1'b1 && cnt < 5000);
    check("baud tick seen", 16'h1, {15'h0, tick});
    if (tick !== 1'b1) give_verdict();
  endtask

  // The first interval after a mode change may be partial, so two ticks are skipped before the measured one.
  task automatic period(input int e);
    repeat (2) next_tick();
    next_tick();
    check("baud period", e[15:0], cnt[15:0]);
  endtask

  task automatic wait_sent(input int n);
    for (int i = 0; i < 300 && far_u.sent_q.size() < n; i++)
      @(posedge sys_clk_i);
    check("chars sent", n[15:0], 16'(far_u.sent_q.size()));
    if (far_u.sent_q.size() < n) give_verdict();
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    fail_count++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    reset_n_i   = 1'b0;
    reg_addr_i  = 4'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    repeat (20) @(posedge sys_clk_i);
    check("tx valid in reset", 16'h0, {15'h0, tx_valid});
    reset_n_i <= 1'b1;
    rd(`SPDB_OFS_RX_DATA, 8'h00);
    rd(`SPDB_OFS_TX_DATA, 8'h00);
    rd(`SPDB_OFS_DIV_LOW, 8'h00);
    rd(`SPDB_OFS_DIV_HIGH, 8'h00);
    rd(4'hf, 8'h00);
    far_u.send(9'h1a5);
    far_u.send(9'h03c);
    rd(`SPDB_OFS_RX_STAT, 8'h03);
    rd(`SPDB_OFS_RX_DATA, 8'ha5);
    rd(`SPDB_OFS_RX_STAT, 8'h02);
    rd(`SPDB_OFS_RX_DATA, 8'h3c);
    rd(`SPDB_OFS_RX_STAT, 8'h00);
    rd(`SPDB_OFS_RX_DATA, 8'h3c);
    far_u.send(9'h011);
    far_u.send(9'h022);
    far_u.send(9'h033);
    rd(`SPDB_OFS_IRQ_STATUS, 8'h05);
    check("irq masked", 16'h0, {15'h0, irq_o});
    wr(`SPDB_OFS_IRQ_MASK, 8'h04);
    #1;
    check("irq unmasked", 16'h1, {15'h0, irq_o});
    wr(`SPDB_OFS_IRQ_STATUS, 8'h04);
    #1;
    check("irq cleared", 16'h0, {15'h0, irq_o});
    rd(`SPDB_OFS_IRQ_STATUS, 8'h01);
    wr(`SPDB_OFS_IRQ_MASK, 8'h01);
    wr(`SPDB_OFS_IRQ_STATUS, 8'h01);
    rd(`SPDB_OFS_IRQ_STATUS, 8'h00);
    rd(`SPDB_OFS_RX_DATA, 8'h11);
    rd(`SPDB_OFS_RX_DATA, 8'h22);
    rd(`SPDB_OFS_RX_STAT, 8'h00);
    wr(`SPDB_OFS_RX_STAT, 8'h40);
    rd(`SPDB_OFS_RX_STAT, 8'h40);
    check("rx nine enable", 16'h1, {15'h0, rx_nine});
    far_u.send(9'h144);
    #1;
    check("irq on receive", 16'h1, {15'h0, irq_o});
    rd(`SPDB_OFS_RX_STAT, 8'h43);
    rd(`SPDB_OFS_RX_DATA, 8'h44);
    wr(`SPDB_OFS_IRQ_STATUS, 8'h01);
    // A second write while the slot is full must be dropped.
    far_u.take_delay = 20;
    wr(`SPDB_OFS_TX_STAT, 8'h41);
    wr(`SPDB_OFS_TX_DATA, 8'h5a);
    wr(`SPDB_OFS_TX_DATA, 8'h33);
    rd(`SPDB_OFS_TX_STAT, 8'h41);
    check("tx char", 16'h15a, {7'h0, tx_char});
    wait_sent(1);
    check("first sent", 16'h15a, {7'h0, far_u.sent_q[0]});
    wr(`SPDB_OFS_TX_STAT, 8'h40);
    wr(`SPDB_OFS_TX_DATA, 8'h77);
    rd(`SPDB_OFS_TX_DATA, 8'h77);
    wait_sent(2);
    check("second sent", 16'h077, {7'h0, far_u.sent_q[1]});
    rd(`SPDB_OFS_IRQ_STATUS, 8'h02);
    repeat (40) @(posedge sys_clk_i);
    check("no extra char", 16'h2, 16'(far_u.sent_q.size()));
    wr(`SPDB_OFS_TX_DATA, 8'h66);
    wr_burst(8'h99, 30);
    wait_sent(4);
    check("refill sent", 16'h099, {7'h0, far_u.sent_q[3]});
    repeat (40) @(posedge sys_clk_i);
    check("burst chars", 16'h4, 16'(far_u.sent_q.size()));
    check("tx nine enable", 16'h1, {15'h0, tx_nine});
    period(64);
    wr(`SPDB_OFS_DIV_HIGH, 8'h01);
    wr(`SPDB_OFS_DIV_LOW, 8'h03);
    rd(`SPDB_OFS_DIV_HIGH, 8'h01);
    rd(`SPDB_OFS_DIV_LOW, 8'h03);
    period(256);
    wr(`SPDB_OFS_TX_STAT, 8'h44);
    period(64);
    wr(`SPDB_OFS_TX_STAT, 8'h54);
    #1;
    check("sync mode", 16'h1, {15'h0, sync_mode});
    period(16);
    wr(`SPDB_OFS_TX_STAT, 8'h40);
    wr(`SPDB_OFS_BAUD_CTRL, 8'h08);
    rd(`SPDB_OFS_BAUD_CTRL, 8'h08);
    period(4160);
    wr(`SPDB_OFS_TX_STAT, 8'h44);
    period(1040);
    // Without a restart the next tick would come about 540 cycles on.
    for (int i = 0; i < 2; i++) begin
      next_tick();
      repeat (500) @(posedge sys_clk_i);
      if (i == 0)
        wr(`SPDB_OFS_DIV_LOW, 8'h03);
      else
        wr(`SPDB_OFS_DIV_HIGH, 8'h01);
      next_tick();
      check("restarted", 16'h1, {15'h0, cnt > 1000});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
